/* common/pcs_tx_pkg.sv */
package pcs_tx_pkg;

    // ------------------------------------------------------------
    // ternary symbols and pairs
    // ------------------------------------------------------------
    typedef logic [1:0] tern_t;
    localparam tern_t TERN_NEG  = 2'h3;
    localparam tern_t TERN_ZERO = 2'h0;
    localparam tern_t TERN_POS  = 2'h1;

    typedef struct packed {
        tern_t ternary_first;
        tern_t ternary_second;
    } pair_s;

    localparam pair_s PAIR_ZERO  = '{TERN_ZERO, TERN_ZERO};
    localparam pair_s PAIR_PLUS  = '{TERN_POS, TERN_POS};
    localparam pair_s PAIR_MINUS = '{TERN_NEG, TERN_NEG};

    // one nibble per coded value, index 7 in the top nibble
    localparam logic [31:0] DATA_MAP  = 32'h5471_3DCF;
    localparam logic [31:0] TRAIN_MAP = 32'h3734_1D1C;

    typedef enum logic [1:0] {
        SEND_SILENCE,
        SEND_TRAINING,
        SEND_NORMAL
    } send_mode_e;

    // ------------------------------------------------------------
    // upstream word as it sits in the fifo
    // ------------------------------------------------------------
    typedef struct packed {
        logic       fault;
        logic       active;
        logic [2:0] data;
    } tx_word_s;

    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 20000;
    localparam int SYMB_PERIOD_NS = 30;
    localparam int SYMB_CYCLES    =
        (SYMB_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYMB_CNT_W     = $clog2(SYMB_CYCLES + 1);
    localparam int DATA_DELAY     = 3;
    localparam int EN_HIST        = 6;

    // ------------------------------------------------------------
    // scrambler
    // ------------------------------------------------------------
    localparam int          SCR_W      = 33;
    localparam logic [32:0] SCR_SEED   = 33'h0_0000_0001;
    localparam int          MASTER_TAP = 12;
    localparam int          SLAVE_TAP  = 19;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_FRAMES = 4'h8;

    localparam int         CTRL_MASTER_BIT = 0;
    localparam int         CTRL_SWAP_BIT   = 1;
    localparam int         CTRL_RUN_BIT    = 2;
    localparam logic [2:0] CTRL_RESET      = 3'h5;

    localparam int STAT_MODE_LSB   = 0;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int STAT_FAULT_BIT  = 3;
    localparam int STAT_LEVEL_LSB  = 4;

endpackage

/* src/pcs_tx_scramble_encoder.sv */
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module pcs_tx_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic                     clock_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     in_valid_i,
    output logic                          in_ready_o,
    input  wire logic [WIDTH-1:0]         in_data_i,
    output logic                          out_valid_o,
    input  wire logic                     out_ready_i,
    output logic [WIDTH-1:0]              out_data_o,
    output logic [$clog2(DEPTH):0]        level_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_q[rd_q];
    assign level_o     = cnt_q;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers wrap by width, so depth must be a power of two
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= push ? wr_q + 1'b1 : wr_q;
            rd_q  <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module pcs_tx_scramble_encoder (
    input  wire logic                    clock_i,
    input  wire logic                    rst_b_i,
    input  wire logic [3:0]              avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic [31:0]                  avs_readdata_o,
    output logic                         avs_waitrequest_o,
    input  wire pcs_tx_pkg::tx_word_s    tx_word_i,
    input  wire logic                    tx_valid_i,
    output logic                         tx_ready_o,
    input  wire pcs_tx_pkg::send_mode_e  send_mode_i,
    input  wire logic                    loc_rcvr_ok_i,
    output pcs_tx_pkg::tern_t            line_sym_o,
    output logic                         pair_start_o
);
    localparam int LVL_W = $clog2(pcs_tx_pkg::FIFO_DEPTH) + 1;
    localparam logic [pcs_tx_pkg::SYMB_CNT_W-1:0] SYMB_LAST =
        pcs_tx_pkg::SYMB_CNT_W'(pcs_tx_pkg::SYMB_CYCLES - 1);
    localparam logic [pcs_tx_pkg::SYMB_CNT_W-1:0] SECOND_AT =
        pcs_tx_pkg::SYMB_CNT_W'(pcs_tx_pkg::SYMB_CYCLES / 2 - 1);

    logic [pcs_tx_pkg::SYMB_CNT_W-1:0] cnt_q;
    logic                              tick;
    logic [2:0]                        ctrl_q;
    logic                              ack_q;
    logic [31:0]                       rdata_q;
    logic [31:0]                       rdata_d;
    logic [15:0]                       frames_q;
    logic [pcs_tx_pkg::SCR_W-1:0]      scr_q;
    logic [pcs_tx_pkg::EN_HIST-1:0]    en_q;
    logic [2:0]                        data_q [pcs_tx_pkg::DATA_DELAY];
    logic                              fault_q;
    pcs_tx_pkg::pair_s                 pair_q;
    pcs_tx_pkg::pair_s                 pair_d;
    pcs_tx_pkg::tern_t                 line_q;
    logic                              start_q;
    pcs_tx_pkg::tx_word_s              fifo_word;
    pcs_tx_pkg::tx_word_s              cur;
    logic                              fifo_valid;
    logic [LVL_W-1:0]                  level;
    logic [2:0]                        raw_key_bits;
    logic [2:0]                        mask_bits;
    logic [2:0]                        coded_bits;
    logic                              idle_balance_bit;
    logic                              en_d3;
    logic                              start_delimiter;
    logic                              esd12;
    logic                              esd3;
    logic                              swap;
    pcs_tx_pkg::pair_s                 train_pair;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    // one wait cycle per access; read data latched in that cycle
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rdata_q;

    always_comb begin
        rdata_d = '0;
        case (avs_address_i)
            pcs_tx_pkg::REG_CTRL: begin
                rdata_d[2:0] = ctrl_q;
            end
            pcs_tx_pkg::REG_STATUS: begin
                rdata_d[pcs_tx_pkg::STAT_MODE_LSB +: 2]     = send_mode_i;
                rdata_d[pcs_tx_pkg::STAT_ACTIVE_BIT]        = en_d3;
                rdata_d[pcs_tx_pkg::STAT_FAULT_BIT]         = fault_q;
                rdata_d[pcs_tx_pkg::STAT_LEVEL_LSB +: LVL_W] = level;
            end
            pcs_tx_pkg::REG_FRAMES: begin
                rdata_d[15:0] = frames_q;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= (avs_read_i | avs_write_i) & ~ack_q;
            rdata_q <= (avs_read_i & ~ack_q) ? rdata_d : rdata_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= pcs_tx_pkg::CTRL_RESET;
        end else if (avs_write_i && ack_q && avs_byteenable_i[0]
                     && avs_address_i == pcs_tx_pkg::REG_CTRL) begin
            ctrl_q <= avs_writedata_i[2:0];
        end
    end

    assign swap = ctrl_q[pcs_tx_pkg::CTRL_SWAP_BIT];

    // ------------------------------------------------------------
    // symbol timing and input fifo
    // ------------------------------------------------------------
    // symbol tick from clock
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= (cnt_q == SYMB_LAST) ? '0 : cnt_q + 1'b1;
        end
    end

    assign tick = cnt_q == SYMB_LAST;

    pcs_tx_fifo #(
        .WIDTH ($bits(pcs_tx_pkg::tx_word_s)),
        .DEPTH (pcs_tx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .in_data_i   (tx_word_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (tick & ctrl_q[pcs_tx_pkg::CTRL_RUN_BIT]),
        .out_data_o  (fifo_word),
        .level_o     (level)
    );

    // an empty fifo reads as idle, so underflow closes the frame
    assign cur = (fifo_valid && ctrl_q[pcs_tx_pkg::CTRL_RUN_BIT]) ? fifo_word : '0;

    // ------------------------------------------------------------
    // scrambler and key bits
    // ------------------------------------------------------------
    // master or slave polynomial
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scr_q <= pcs_tx_pkg::SCR_SEED;
        end else if (tick) begin
            scr_q <= {scr_q[31:0], scr_q[32] ^ (ctrl_q[pcs_tx_pkg::CTRL_MASTER_BIT]
                     ? scr_q[pcs_tx_pkg::MASTER_TAP] : scr_q[pcs_tx_pkg::SLAVE_TAP])};
        end
    end

    assign raw_key_bits     = {scr_q[6] ^ scr_q[16], scr_q[3] ^ scr_q[8], scr_q[0]};
    assign idle_balance_bit = scr_q[7] ^ scr_q[9] ^ scr_q[12] ^ scr_q[14];

    assign mask_bits[2:1] = (send_mode_i == pcs_tx_pkg::SEND_SILENCE) ? 2'h0
                                                                     : raw_key_bits[2:1];
    assign mask_bits[0]   = raw_key_bits[0];

    assign en_d3      = en_q[pcs_tx_pkg::DATA_DELAY-1];
    assign coded_bits = en_d3 ? (mask_bits ^ data_q[pcs_tx_pkg::DATA_DELAY-1])
                              : {mask_bits[2] ^ loc_rcvr_ok_i, mask_bits[1:0]};

    // ------------------------------------------------------------
    // frame history and delimiters
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_q <= '0;
            for (int i = 0; i < pcs_tx_pkg::DATA_DELAY; i++) begin
                data_q[i] <= '0;
            end
        end else if (tick) begin
            en_q      <= {en_q[pcs_tx_pkg::EN_HIST-2:0], cur.active};
            data_q[0] <= cur.data;
            for (int i = 1; i < pcs_tx_pkg::DATA_DELAY; i++) begin
                data_q[i] <= data_q[i-1];
            end
        end
    end

    // start overrides end if frames come closer than the delimiters
    assign start_delimiter   = cur.active & ~en_d3;
    assign esd12 = (en_q[3] & ~en_q[2]) | (en_q[4] & ~en_q[3]);
    assign esd3  = en_q[5] & ~en_q[4];

    // fault held to third end pair; new fault wins over clear
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_q <= 1'b0;
        end else if (tick) begin
            fault_q <= (cur.active & cur.fault) | (fault_q & ~esd3);
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frames_q <= '0;
        end else if (tick && esd3 && send_mode_i == pcs_tx_pkg::SEND_NORMAL) begin
            frames_q <= frames_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // ternary mapper
    // ------------------------------------------------------------
    assign train_pair = pcs_tx_pkg::pair_s'(pcs_tx_pkg::TRAIN_MAP[coded_bits*4 +: 4]);

    always_comb begin
        pair_d = pcs_tx_pkg::PAIR_ZERO;
        case (send_mode_i)
            pcs_tx_pkg::SEND_SILENCE: begin
                pair_d = pcs_tx_pkg::PAIR_ZERO;
            end
            pcs_tx_pkg::SEND_TRAINING: begin
                pair_d = train_pair;
            end
            pcs_tx_pkg::SEND_NORMAL: begin
                if (start_delimiter || (esd12 && !en_d3)) begin
                    pair_d = pcs_tx_pkg::PAIR_ZERO;
                end else if (en_d3) begin
                    pair_d = pcs_tx_pkg::pair_s'(pcs_tx_pkg::DATA_MAP[coded_bits*4 +: 4]);
                end else if (esd3) begin
                    pair_d = fault_q ? pcs_tx_pkg::PAIR_MINUS : pcs_tx_pkg::PAIR_PLUS;
                end else begin
                    pair_d = train_pair;
                    if (idle_balance_bit && coded_bits[0]) begin
                        pair_d.ternary_first = train_pair.ternary_second;
                    end
                end
            end
            default: begin
                pair_d = pcs_tx_pkg::PAIR_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // interleaver
    // ------------------------------------------------------------
    // two line symbols per pair
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pair_q  <= pcs_tx_pkg::PAIR_ZERO;
            line_q  <= pcs_tx_pkg::TERN_ZERO;
            start_q <= 1'b0;
        end else begin
            start_q <= tick;
            if (tick) begin
                pair_q <= pair_d;
                line_q <= swap ? pair_d.ternary_second : pair_d.ternary_first;
            end else if (cnt_q == SECOND_AT) begin
                line_q <= swap ? pair_q.ternary_first : pair_q.ternary_second;
            end
        end
    end

    assign line_sym_o   = line_q;
    assign pair_start_o = start_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    tick_period_a: assert property (tick |=> !tick ##1 tick)
        else $error("symbol tick period wrong");
    scramble_step_a: assert property (tick |=> scr_q[0] == $past(scr_q[32]
        ^ (ctrl_q[0] ? scr_q[12] : scr_q[19])))
        else $error("scrambler step wrong");
    mask_silence_a: assert property (send_mode_i == pcs_tx_pkg::SEND_SILENCE
        && !en_d3 |-> coded_bits[2:1] == {loc_rcvr_ok_i, 1'b0})
        else $error("mask not cleared in silence");
    data_nonzero_a: assert property (tick && en_d3 && !start_delimiter
        && send_mode_i == pcs_tx_pkg::SEND_NORMAL |=> pair_q != 4'h0)
        else $error("data sent as zero pair");
    start_delim_a: assert property (tick && start_delimiter && send_mode_i == pcs_tx_pkg::SEND_NORMAL
        |=> pair_q == 4'h0 ##1 line_q == 2'h0)
        else $error("start delimiter pair wrong");
    end_good_a: assert property (tick && esd3 && !en_d3 && !start_delimiter && !fault_q
        && send_mode_i == pcs_tx_pkg::SEND_NORMAL |=> pair_q == 4'h5)
        else $error("end delimiter third pair wrong");
    end_fault_a: assert property (tick && esd3 && !en_d3 && !start_delimiter && fault_q
        && send_mode_i == pcs_tx_pkg::SEND_NORMAL |=> pair_q == 4'hF)
        else $error("fault end delimiter wrong");
    silence_zero_a: assert property (tick && send_mode_i == pcs_tx_pkg::SEND_SILENCE
        |=> pair_q == 4'h0 [*2])
        else $error("silence not zero pair");
    interleave_order_a: assert property (start_q && !swap && $stable(swap)
        |-> line_q == pair_q[3:2] ##1 line_q == pair_q[1:0])
        else $error("interleave order wrong");
endmodule

`default_nettype wire

/* tb/pcs_tx_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module pcs_tx_partner (
    input  wire logic                 clock_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 tx_ready_i,
    input  wire pcs_tx_pkg::tern_t    line_sym_i,
    input  wire logic                 pair_start_i,
    output pcs_tx_pkg::tx_word_s      tx_word_o,
    output logic                      tx_valid_o
);
    pcs_tx_pkg::tx_word_s words[$];
    pcs_tx_pkg::pair_s    pairs[$];
    pcs_tx_pkg::tern_t    first_q;
    logic                 second_q;
    int                   gap_q;
    int                   gap_errors = 0;

    // ------------------------------------------------------------
    // upstream word source
    // ------------------------------------------------------------
    // words offered on every clock while the queue holds any
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_valid_o <= 1'b0;
            tx_word_o  <= '0;
        end else begin
            if (tx_valid_o && tx_ready_i) begin
                void'(words.pop_front());
            end
            if (words.size() != 0) begin
                tx_valid_o <= 1'b1;
                tx_word_o  <= words[0];
            end else begin
                tx_valid_o <= 1'b0;
                // released bus inverts every bit each clock, so the stale word comes back on every second clock
                tx_word_o  <= ~tx_word_o;
            end
        end
    end

    // ------------------------------------------------------------
    // line receiver
    // ------------------------------------------------------------
    // de-interleave first then second
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            second_q <= 1'b0;
            gap_q    <= 0;
        end else begin
            gap_q    <= pair_start_i ? 1 : gap_q + 1;
            if (pair_start_i && gap_q != 0 && gap_q != 2) begin
                gap_errors++;
            end
            second_q <= pair_start_i;
            first_q  <= line_sym_i;
            if (second_q) begin
                pairs.push_back(pcs_tx_pkg::pair_s'({first_q, line_sym_i}));
            end
        end
    end
endmodule

`default_nettype wire

/* tb/tb_pcs_tx_scramble_encoder.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %0t mismatch got %0h expected %0h", $time, (got), (exp)); \
        end \
    end

module tb_pcs_tx_scramble_encoder;
    logic                   clock_i;
    logic                   rst_b_i;
    logic [3:0]             avs_address_i;
    logic                   avs_read_i;
    logic                   avs_write_i;
    logic [31:0]            avs_writedata_i;
    logic [3:0]             avs_byteenable_i;
    logic [31:0]            avs_readdata_o;
    logic                   avs_waitrequest_o;
    pcs_tx_pkg::tx_word_s   tx_word_i;
    logic                   tx_valid_i;
    logic                   tx_ready_o;
    pcs_tx_pkg::send_mode_e send_mode_i;
    logic                   loc_rcvr_ok_i;
    pcs_tx_pkg::tern_t      line_sym_o;
    logic                   pair_start_o;
    logic [31:0]            q;
    int                     num_errors = 0;
    int                     num_checks = 0;

    pcs_tx_scramble_encoder dut_u (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .tx_word_i(tx_word_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .send_mode_i(send_mode_i), .loc_rcvr_ok_i(loc_rcvr_ok_i),
        .line_sym_o(line_sym_o), .pair_start_o(pair_start_o)
    );

    pcs_tx_partner partner_u (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .tx_ready_i(tx_ready_o),
        .line_sym_i(line_sym_o), .pair_start_i(pair_start_o),
        .tx_word_o(tx_word_i), .tx_valid_o(tx_valid_i)
    );

    always #10 clock_i = ~clock_i;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic bus_cycle(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= rd;
        avs_write_i     <= !rd;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            $display("[FAIL] %0t bus answer never came", $time);
            num_errors++;
            wrap_up();
        end
    endtask

    // mode changes only just after a pair begins
    task automatic set_mode(input pcs_tx_pkg::send_mode_e m);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pair_start_o !== 1'b1 && n < 10);
        send_mode_i <= m;
        `CHK(pair_start_o, 1'b1)
    endtask

    // let the pair already on the line land before clearing the capture
    task automatic grab(input int cycles);
        @(posedge clock_i);
        @(negedge clock_i);
        partner_u.pairs.delete();
        repeat (cycles) @(posedge clock_i);
    endtask

    task automatic check_frame(input int n, input pcs_tx_pkg::pair_s last);
        int i;
        i = 0;
        while (i < partner_u.pairs.size() && partner_u.pairs[i] !== pcs_tx_pkg::PAIR_ZERO) i++;
        `CHK(partner_u.pairs.size() >= i + n + 7, 1'b1)
        if (partner_u.pairs.size() < i + n + 7) return;
        for (int k = 0; k < 3; k++) `CHK(partner_u.pairs[i+k], pcs_tx_pkg::PAIR_ZERO)
        for (int k = 0; k < n; k++) `CHK(partner_u.pairs[i+3+k] !== pcs_tx_pkg::PAIR_ZERO, 1'b1)
        `CHK(partner_u.pairs[i+n+3], pcs_tx_pkg::PAIR_ZERO)
        `CHK(partner_u.pairs[i+n+4], pcs_tx_pkg::PAIR_ZERO)
        `CHK(partner_u.pairs[i+n+5], last)
        `CHK(partner_u.pairs[i+n+6] !== pcs_tx_pkg::PAIR_ZERO, 1'b1)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clock_i          = 1'b0;
        rst_b_i          = 1'b0;
        avs_address_i    = 4'h0;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_writedata_i  = 32'h0;
        avs_byteenable_i = 4'hF;
        send_mode_i      = pcs_tx_pkg::SEND_SILENCE;
        loc_rcvr_ok_i    = 1'b1;
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        bus_cycle(1'b1, pcs_tx_pkg::REG_CTRL, 32'h0);
        `CHK(q, 32'h0000_0005)
        bus_cycle(1'b0, pcs_tx_pkg::REG_FRAMES, 32'h0000_FFFF);
        bus_cycle(1'b1, pcs_tx_pkg::REG_FRAMES, 32'h0);
        `CHK(q, 32'h0000_0000)
        bus_cycle(1'b1, 4'hC, 32'h0);
        `CHK(q, 32'h0000_0000)
        // silence: zero pairs only
        grab(40);
        `CHK(partner_u.pairs.size() >= 19, 1'b1)
        foreach (partner_u.pairs[k]) `CHK(partner_u.pairs[k], pcs_tx_pkg::PAIR_ZERO)
        // training: delimiter pair never used
        set_mode(pcs_tx_pkg::SEND_TRAINING);
        grab(40);
        foreach (partner_u.pairs[k]) `CHK(partner_u.pairs[k] !== pcs_tx_pkg::PAIR_ZERO, 1'b1)
        // fill the buffer with the drain stopped
        bus_cycle(1'b0, pcs_tx_pkg::REG_CTRL, 32'h0000_0001);
        set_mode(pcs_tx_pkg::SEND_NORMAL);
        @(negedge clock_i);
        for (int k = 0; k < 16; k++) begin
            partner_u.words.push_back(pcs_tx_pkg::tx_word_s'{fault: 1'b0, active: 1'b1,
                                                             data: k[2:0]});
        end
        for (int n = 0; n < 60 && partner_u.words.size() != 0; n++) @(posedge clock_i);
        repeat (2) @(posedge clock_i);
        `CHK(tx_ready_o, 1'b0)
        bus_cycle(1'b1, pcs_tx_pkg::REG_STATUS, 32'h0);
        `CHK(q[8:4], 5'h10)
        `CHK(q[1:0], 2'h2)
        // run: one long frame, normal end
        @(negedge clock_i);
        partner_u.pairs.delete();
        bus_cycle(1'b0, pcs_tx_pkg::REG_CTRL, 32'h0000_0005);
        repeat (100) @(posedge clock_i);
        check_frame(16, pcs_tx_pkg::PAIR_PLUS);
        `CHK(tx_ready_o, 1'b1)
        // short frame with a fault in mid-frame
        grab(0);
        @(negedge clock_i);
        partner_u.words.push_back(pcs_tx_pkg::tx_word_s'{fault: 1'b0, active: 1'b1, data: 3'h7});
        partner_u.words.push_back(pcs_tx_pkg::tx_word_s'{fault: 1'b1, active: 1'b1, data: 3'h0});
        partner_u.words.push_back(pcs_tx_pkg::tx_word_s'{fault: 1'b0, active: 1'b1, data: 3'h4});
        repeat (60) @(posedge clock_i);
        check_frame(3, pcs_tx_pkg::PAIR_MINUS);
        bus_cycle(1'b1, pcs_tx_pkg::REG_FRAMES, 32'h0);
        `CHK(q, 32'h0000_0002)
        bus_cycle(1'b1, pcs_tx_pkg::REG_STATUS, 32'h0);
        `CHK(q[8:4], 5'h00)
        `CHK(partner_u.gap_errors, 0)
        wrap_up();
    end
endmodule

`undef CHK
`default_nettype wire
